// ---- inc/cst_pkg.sv ----
package cst_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_CLOCK_SOURCE_SELECT_OFS = 8'h65;
    localparam logic [7:0] CLOCK_GENERATION_CONTROL_OFS = 8'h66;
    localparam logic [7:0] LEFT_GAIN_ATTACK_TIMING_OFS  = 8'h67;
    localparam logic [7:0] LEFT_GAIN_DECAY_TIMING_OFS   = 8'h68;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_CLOCK_SOURCE_RST = 8'h00;
    localparam logic [7:0] CLOCK_GENERATION_RST  = 8'h02;
    localparam logic [7:0] LEFT_ATTACK_RST       = 8'h00;
    localparam logic [7:0] LEFT_DECAY_RST        = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CORE_SRC_BIT      = 0;
    localparam int DIV_SRC_LSB       = 6;
    localparam int PLL_SRC_LSB       = 4;
    localparam int PLL_N_LSB         = 0;
    localparam int TIME_SRC_BIT      = 7;
    localparam int TIME_BASE_LSB     = 5;
    localparam int TIME_MULT_LSB     = 2;
    // ------------------------------------------------------------
    // source codes and decode constants
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_MASTER_CLOCK = 2'h0;
    localparam logic [1:0] SRC_BIT_CLOCK    = 2'h2;
    localparam logic [4:0] PLL_N_CODE0      = 5'h10;
    localparam logic [4:0] PLL_N_CODE1      = 5'h11;
    // baseline times in milliseconds
    localparam logic [8:0] ATTACK_BASE_MS [4] = '{9'h007, 9'h008, 9'h00a, 9'h00b};
    localparam logic [8:0] DECAY_BASE_MS  [4] = '{9'h032, 9'h096, 9'h0fa, 9'h15e};
    // decay cap in milliseconds, indexed by adc ratio in half steps (ratio*2-2)
    localparam logic [15:0] DECAY_CAP_MS [11] = '{
        16'h0fa0, 16'h15e0, 16'h1f40, 16'h2580, 16'h2bc0, 16'h2bc0,
        16'h3e80, 16'h3e80, 16'h4b00, 16'h5780, 16'h5780};
endpackage

// ---- core/cst_time_calc.sv ----
// ------------------------------------------------------------
// applied agc time: baseline times factor, clipped to a cap
// ------------------------------------------------------------
module cst_time_calc
(
    input  wire logic [7:0]  timing_reg_in,
    input  wire logic [8:0]  base_ms_in,
    input  wire logic [15:0] cap_ms_in,
    input  wire logic        use_cap_in,
    output logic             reg_selected_out,
    output logic      [15:0] time_ms_out
);
    logic [2:0]  mult_code;
    logic [15:0] scaled_ms;
    // factor is two raised to the code
    assign mult_code        = timing_reg_in[cst_pkg::TIME_MULT_LSB +: 3];
    assign scaled_ms        = 16'({7'h00, base_ms_in} << mult_code);
    assign reg_selected_out = timing_reg_in[cst_pkg::TIME_SRC_BIT];
    // fields ignored when legacy source is chosen
    assign time_ms_out = !reg_selected_out ? 16'h0000 :
                         (use_cap_in && scaled_ms > cap_ms_in) ? cap_ms_in : scaled_ms;
endmodule // cst_time_calc

// ---- core/cst_regs.sv ----
// Contract
// RULE1: core clock bit 0 picks pll divider output at 0 and clock divider output at 1, reset 0.
// RULE2: core clock bits 7 to 1 are read-only zero and software must not write ones there.
// RULE3: divider input field bits 7:6 picks master clock at 00 and bit clock at 10, reset 00.
// RULE4: pll reference field bits 5:4 picks master clock at 00 and bit clock at 10, reset 00.
// RULE5: software must not program the reserved source codes 01 or 11.
// RULE6: pll divider bits 3:0 decode 0000 as 16, 0001 as 17, others as themselves, reset 0010.
// RULE7: attack bit 7 takes attack time from legacy register 26 at 0 and from here at 1.
// RULE8: attack baseline bits 6:5 are 7, 8, 10 and 11 ms, reset 00.
// RULE9: attack multiplier bits 4:2 are factors two to the code, reset 000.
// RULE10: software writes only zeros into bits 1:0 of the attack and decay registers.
// RULE11: decay bit 7 takes decay time from legacy register 26 at 0 and from here at 1.
// RULE12: decay baseline bits 6:5 are 50, 150, 250 and 350 ms, reset 00.
// RULE13: decay multiplier bits 4:2 are factors two to the code, reset 000.
// RULE14: the decay time is capped from 4 s at adc ratio 1 up to 22.4 s at ratio 5.5 or 6.
// RULE15: the applied time is baseline times factor when selected, fields ignored otherwise.
module cst_regs
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic [3:0]  adc_rate_divider_ratio_in,
    output logic      [7:0]  rd_data_out,
    output logic             core_clock_input_sel_out,
    output logic      [1:0]  clock_divider_input_sel_out,
    output logic      [1:0]  pll_reference_input_sel_out,
    output logic      [4:0]  pll_divider_n_out,
    output logic             attack_from_reg_out,
    output logic      [15:0] attack_time_ms_out,
    output logic             decay_from_reg_out,
    output logic      [15:0] decay_time_ms_out
);
    // ------------------------------------------------------------
    // register storage and decode
    // ------------------------------------------------------------
    logic        core_src_q;
    logic [7:0]  clk_gen_q;
    logic [7:0]  attack_q;
    logic [7:0]  decay_q;
    logic        hit_core;
    logic        hit_gen;
    logic        hit_attack;
    logic        hit_decay;
    logic [7:0]  rd_data_d;
    logic [4:0]  pll_n_d;
    logic [15:0] attack_ms;
    logic [15:0] decay_ms;
    logic        attack_sel;
    logic        decay_sel;
    logic [15:0] decay_cap;
    logic        ratio_ok;

    // decodes a four-bit n code to its divider value
    function automatic logic [4:0] pll_n_decode(input logic [3:0] code);
        if (code == 4'h0)
        begin
            return cst_pkg::PLL_N_CODE0;
        end
        else if (code == 4'h1)
        begin
            return cst_pkg::PLL_N_CODE1;
        end
        return {1'b0, code};
    endfunction

    // address decode
    assign hit_core   = addr_in == cst_pkg::CORE_CLOCK_SOURCE_SELECT_OFS;
    assign hit_gen    = addr_in == cst_pkg::CLOCK_GENERATION_CONTROL_OFS;
    assign hit_attack = addr_in == cst_pkg::LEFT_GAIN_ATTACK_TIMING_OFS;
    assign hit_decay  = addr_in == cst_pkg::LEFT_GAIN_DECAY_TIMING_OFS;

    // read mux; upper core bits read zero, unmapped reads zero
    assign rd_data_d = hit_core   ? {7'h00, core_src_q} :      // [RULE2]
                       hit_gen    ? clk_gen_q :
                       hit_attack ? attack_q :
                       hit_decay  ? decay_q : 8'h00;

    assign pll_n_d = pll_n_decode(clk_gen_q[cst_pkg::PLL_N_LSB +: 4]);   // [RULE6]

    // ratio code is ratio*2-2; codes 0..10 are valid, others leave cap off
    assign ratio_ok  = adc_rate_divider_ratio_in <= 4'ha;
    assign decay_cap = ratio_ok ? cst_pkg::DECAY_CAP_MS[adc_rate_divider_ratio_in] : 16'hffff;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            core_src_q <= cst_pkg::CORE_CLOCK_SOURCE_RST[0];    // [RULE1]
            clk_gen_q  <= cst_pkg::CLOCK_GENERATION_RST;        // [RULE3] [RULE4] [RULE6]
            attack_q   <= cst_pkg::LEFT_ATTACK_RST;             // [RULE7] [RULE8] [RULE9]
            decay_q    <= cst_pkg::LEFT_DECAY_RST;              // [RULE11] [RULE12] [RULE13]
        end
        else if (wr_en_in)
        begin
            if (hit_core)
            begin
                core_src_q <= wr_data_in[cst_pkg::CORE_SRC_BIT];   // [RULE1] [RULE2]
            end
            if (hit_gen)
            begin
                clk_gen_q <= wr_data_in;
            end
            if (hit_attack)
            begin
                attack_q <= wr_data_in;
            end
            if (hit_decay)
            begin
                decay_q <= wr_data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // applied time calculation
    // ------------------------------------------------------------
    cst_time_calc u_attack
    (
        .timing_reg_in    (attack_q),
        .base_ms_in       (cst_pkg::ATTACK_BASE_MS[attack_q[cst_pkg::TIME_BASE_LSB +: 2]]),
        .cap_ms_in        (16'hffff),
        .use_cap_in       (1'b0),
        .reg_selected_out (attack_sel),
        .time_ms_out      (attack_ms)
    );  // [RULE8] [RULE9] [RULE15]

    cst_time_calc u_decay
    (
        .timing_reg_in    (decay_q),
        .base_ms_in       (cst_pkg::DECAY_BASE_MS[decay_q[cst_pkg::TIME_BASE_LSB +: 2]]),
        .cap_ms_in        (decay_cap),
        .use_cap_in       (1'b1),
        .reg_selected_out (decay_sel),
        .time_ms_out      (decay_ms)
    );  // [RULE12] [RULE13] [RULE14] [RULE15]

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_data_out                 <= 8'h00;
            core_clock_input_sel_out    <= 1'b0;
            clock_divider_input_sel_out <= cst_pkg::SRC_MASTER_CLOCK;
            pll_reference_input_sel_out <= cst_pkg::SRC_MASTER_CLOCK;
            pll_divider_n_out           <= 5'h02;
            attack_from_reg_out         <= 1'b0;
            attack_time_ms_out          <= 16'h0000;
            decay_from_reg_out          <= 1'b0;
            decay_time_ms_out           <= 16'h0000;
        end
        else
        begin
            rd_data_out                 <= rd_en_in ? rd_data_d : rd_data_out;
            core_clock_input_sel_out    <= core_src_q;                               // [RULE1]
            clock_divider_input_sel_out <= clk_gen_q[cst_pkg::DIV_SRC_LSB +: 2];    // [RULE3]
            pll_reference_input_sel_out <= clk_gen_q[cst_pkg::PLL_SRC_LSB +: 2];    // [RULE4]
            pll_divider_n_out           <= pll_n_d;                                  // [RULE6]
            attack_from_reg_out         <= attack_sel;                               // [RULE7]
            attack_time_ms_out          <= attack_ms;                                // [RULE15]
            decay_from_reg_out          <= decay_sel;                                // [RULE11]
            decay_time_ms_out           <= decay_ms;                                 // [RULE14]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_core_upper_zero: assert property (@(posedge ref_clk_in)   // [RULE2]
        disable iff (!rst_n_in)
        rd_en_in && hit_core |=> rd_data_out[7:1] == 7'h00)
        else $error("core clock upper bits not zero");
    a_core_sel_follow: assert property (@(posedge ref_clk_in)   // [RULE1]
        disable iff (!rst_n_in)
        wr_en_in && hit_core |=> ##1 core_clock_input_sel_out == $past(wr_data_in[0], 2))
        else $error("core clock select not applied");
    a_div_src_follow: assert property (@(posedge ref_clk_in)   // [RULE3]
        disable iff (!rst_n_in)
        wr_en_in && hit_gen |=> ##1 clock_divider_input_sel_out == $past(wr_data_in[7:6], 2))
        else $error("divider source not applied");
    a_pll_src_follow: assert property (@(posedge ref_clk_in)   // [RULE4]
        disable iff (!rst_n_in)
        wr_en_in && hit_gen |=> ##1 pll_reference_input_sel_out == $past(wr_data_in[5:4], 2))
        else $error("pll source not applied");
    a_pll_n_range: assert property (@(posedge ref_clk_in)   // [RULE6]
        disable iff (!rst_n_in)
        wr_en_in && hit_gen && wr_data_in[3:0] == 4'h0 |=> ##1 pll_divider_n_out == 5'h10)
        else $error("pll n code zero not sixteen");
    a_attack_legacy_zero: assert property (@(posedge ref_clk_in)   // [RULE7]
        disable iff (!rst_n_in)
        !attack_from_reg_out |-> attack_time_ms_out == 16'h0000)
        else $error("attack fields used in legacy mode");
    a_attack_mult_max: assert property (@(posedge ref_clk_in)   // [RULE8]
        disable iff (!rst_n_in)
        wr_en_in && hit_attack && wr_data_in == 8'hfc |=> ##1 attack_time_ms_out == 16'h0580)
        else $error("attack 11 ms times 128 wrong");
    a_decay_legacy_zero: assert property (@(posedge ref_clk_in)   // [RULE11]
        disable iff (!rst_n_in)
        !decay_from_reg_out |-> decay_time_ms_out == 16'h0000)
        else $error("decay fields used in legacy mode");
    a_decay_base_min: assert property (@(posedge ref_clk_in)   // [RULE12]
        disable iff (!rst_n_in)
        wr_en_in && hit_decay && wr_data_in == 8'h80 |=> ##1 decay_time_ms_out == 16'h0032)
        else $error("decay 50 ms baseline wrong");
    a_decay_cap_hold: assert property (@(posedge ref_clk_in)   // [RULE14]
        disable iff (!rst_n_in)
        adc_rate_divider_ratio_in == 4'h0 |=> decay_time_ms_out <= 16'h0fa0)
        else $error("decay exceeds cap at ratio one");
    // every cap is far above 100 ms, so the factor shows at any ratio
    a_decay_mult: assert property (@(posedge ref_clk_in)   // [RULE13]
        disable iff (!rst_n_in)
        decay_from_reg_out && $stable(decay_q) && decay_q[4:2] == 3'h1 && decay_q[6:5] == 2'h0
        |=> decay_time_ms_out == 16'h0064)
        else $error("decay factor two wrong");

    c_core_write: cover property (@(posedge ref_clk_in) wr_en_in && hit_core && wr_data_in[0]);
    c_bit_clock: cover property (@(posedge ref_clk_in)
        clock_divider_input_sel_out == cst_pkg::SRC_BIT_CLOCK);
    c_attack_reg: cover property (@(posedge ref_clk_in) attack_from_reg_out);
    c_decay_capped: cover property (@(posedge ref_clk_in)
        decay_from_reg_out && decay_time_ms_out == decay_cap && ratio_ok);
endmodule // cst_regs

// ---- test/test_clock_source_agc_timing_regs.sv ----
module test_clock_source_agc_timing_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wr_en_in = 1'b0;
    logic        rd_en_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  wr_data_in = 8'h00;
    logic [3:0]  adc_rate_divider_ratio_in = 4'h0;
    logic [7:0]  rd_data_out;
    logic        core_sel;
    logic [1:0]  div_sel;
    logic [1:0]  pll_sel;
    logic [4:0]  pll_n;
    logic        atk_from;
    logic [15:0] atk_ms;
    logic        dec_from;
    logic [15:0] dec_ms;
    logic [7:0]  sh [4] = '{8'h00, 8'h02, 8'h00, 8'h00};
    int          bad_count = 0;
    int          checked = 0;
    cst_regs dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .adc_rate_divider_ratio_in(adc_rate_divider_ratio_in), .rd_data_out(rd_data_out),
        .core_clock_input_sel_out(core_sel), .clock_divider_input_sel_out(div_sel),
        .pll_reference_input_sel_out(pll_sel), .pll_divider_n_out(pll_n),
        .attack_from_reg_out(atk_from), .attack_time_ms_out(atk_ms),
        .decay_from_reg_out(dec_from), .decay_time_ms_out(dec_ms));
    // 50 MHz clock
    always #10 ref_clk_in = ~ref_clk_in;
    // ------------------------------------------------------------
    // expectation functions
    // ------------------------------------------------------------
    function automatic logic [4:0] exp_n(input logic [3:0] c);
        return (c == 4'h0) ? 5'h10 : (c == 4'h1) ? 5'h11 : {1'b0, c};
    endfunction
    function automatic logic [15:0] exp_t(input logic [7:0] r, input bit dec);
        logic [15:0] b;
        logic [15:0] cap;
        logic [15:0] t;
        case (r[6:5])
            2'h0: b = dec ? 16'h0032 : 16'h0007;
            2'h1: b = dec ? 16'h0096 : 16'h0008;
            2'h2: b = dec ? 16'h00fa : 16'h000a;
            default: b = dec ? 16'h015e : 16'h000b;
        endcase
        case (adc_rate_divider_ratio_in)
            4'h0: cap = 16'h0fa0;
            4'h1: cap = 16'h15e0;
            4'h2: cap = 16'h1f40;
            4'h3: cap = 16'h2580;
            4'h4, 4'h5: cap = 16'h2bc0;
            4'h6, 4'h7: cap = 16'h3e80;
            4'h8: cap = 16'h4b00;
            4'h9, 4'ha: cap = 16'h5780;
            default: cap = 16'hffff;
        endcase
        t = b << r[4:2];
        if (dec && t > cap)
            t = cap;
        return r[7] ? t : 16'h0000;
    endfunction
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
        if (a >= 8'h65 && a <= 8'h68)
            sh[a - 8'h65] = (a == 8'h65) ? {7'h00, d[0]} : d;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        chk({8'h00, rd_data_out}, {8'h00, exp});
    endtask
    task automatic check_all();
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({15'h0000, core_sel}, {15'h0000, sh[0][0]});
        chk({14'h0000, div_sel}, {14'h0000, sh[1][7:6]});
        chk({14'h0000, pll_sel}, {14'h0000, sh[1][5:4]});
        chk({11'h000, pll_n}, {11'h000, exp_n(sh[1][3:0])});
        chk({15'h0000, atk_from}, {15'h0000, sh[2][7]});
        chk(atk_ms, exp_t(sh[2], 1'b0));
        chk({15'h0000, dec_from}, {15'h0000, sh[3][7]});
        chk(dec_ms, exp_t(sh[3], 1'b1));
        for (int i = 0; i < 4; i++)
            rd_chk(8'h65 + 8'(i), sh[i]);
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(32'h1762));
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        check_all();
        rd_chk(8'h64, 8'h00);
        // every pll divider code
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h66, {2'h2, 2'h0, 4'(c)});
            check_all();
        end
        // every baseline and factor, with the cap table swept
        for (int k = 0; k < 32; k++)
        begin
            @(posedge ref_clk_in);
            adc_rate_divider_ratio_in <= 4'(k % 12);
            wr(8'h67, {1'b1, 5'(k), 2'h0});
            wr(8'h68, {1'b1, 5'(31 - k), 2'h0});
            check_all();
        end
        // random traffic, including unmapped writes
        for (int i = 0; i < 60; i++)
        begin
            a = 8'h64 + 8'($urandom_range(5));
            d = 8'($urandom);
            if (a == 8'h65)
                d = {7'h00, d[0]};
            if (a == 8'h66)
                d = {d[7], 1'b0, d[5], 1'b0, d[3:0]};
            if (a == 8'h67 || a == 8'h68)
                d = {d[7:2], 2'h0};
            @(posedge ref_clk_in);
            adc_rate_divider_ratio_in <= 4'($urandom_range(15));
            wr(a, d);
            check_all();
        end
        end_of_test();
    end
    // hang guard, well beyond the expected run length
    initial
    begin
        #(20 * 60000);
        bad_count++;
        end_of_test();
    end
endmodule // test_clock_source_agc_timing_regs
